// >>> rtl/zero_delay_cfg.svh
`ifndef ZERO_DELAY_CFG_SVH
`define ZERO_DELAY_CFG_SVH
// Contract
// - selection-control bit 0 means pin-driven input choice (0x0021 / 0x052A bit 0).
// - selection-control bit 1 takes the input choice from registers.
// - second map: 0x0487 bit 0 turns zero delay on (1) or off (0).
// - under zero delay and register control, bits 2:1 of 0x0487 pick input 0..2.
// - zero-delay input choice is ignored under pin control.
// - zero delay on makes the normal input-select bits unused.
// - zero delay with register control uses the zero-delay input choice.
// - zero delay and selection-control both high: pins choose, no selector used; code does so only on the second map with map-control bit 1 set.
// - with zero delay on, input 3 is feedback only, never a reference.
// - with zero delay on, automatic input switching is off; manual only.

// register indices; byte address is four times the index
`define IDX_MAP_CONTROL 14'h0000
`define IDX_SELECT_STATUS 14'h0001
`define IDX_NORMAL_INPUT 14'h0002
`define IDX_SEL_CTRL_A 14'h0021
`define IDX_FORCE_ON_HIGH 14'h0139
`define IDX_FORCE_ON_LOW 14'h0140
`define IDX_ZERO_DELAY_B 14'h0487
`define IDX_SEL_CTRL_B 14'h052A
`define IDX_MODE_CODE 14'h091C

// field positions
`define POS_VARIANT_B 0
`define POS_STRICT_OVERRIDE 1
`define POS_ZD_ENABLE 0
`define POS_ZD_CHOICE_LSB 1
`define POS_AUTO_ENABLE 2
`define POS_CODE_ERROR 8
`define POS_CHOICE_ERROR 9

// values and reset values
`define MODE_ZERO_DELAY 3'h3
`define MODE_NORMAL 3'h4
`define CHOICE_FEEDBACK 2'h3
`define RST_MODE_CODE 3'h4
`define RST_MAP_CONTROL 2'h0
`define RST_INPUT_CHOICE 2'h0
`define RST_FORCE_ON 12'h000
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// >>> rtl/zero_delay_pkg.sv
package zero_delay_pkg;
    typedef struct packed {
        logic [13:0] idx;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_type;

    typedef enum logic [1:0] {
        SRC_NORMAL_REG = 2'b00,
        SRC_PINS = 2'b01,
        SRC_ZERO_DELAY_REG = 2'b10,
        SRC_AUTO = 2'b11
    } sel_source_type;

    typedef struct packed {
        logic zero_delay_on;
        logic input3_reference_ok;
        logic auto_switch_active;
        sel_source_type source;
        logic [1:0] choice;
    } selection_type;
endpackage

// >>> rtl/axil_reg_port.sv
`include "zero_delay_cfg.svh"
module axil_reg_port (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output zero_delay_pkg::wr_req_type wr_req,
    output logic wr_fire,
    input wire logic wr_hit,
    output logic [13:0] rd_idx,
    input wire logic [31:0] rd_data,
    input wire logic rd_hit
);
    logic aw_held_ff;
    logic w_held_ff;
    logic [13:0] aw_idx_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_req = '{idx: aw_idx_ff, data: w_data_ff, strb: w_strb_ff};
    assign rd_idx = s_axi_araddr[15:2];
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // address and data are caught independently, in either order
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_held_ff <= 1'b0;
            aw_idx_ff <= 14'h0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            aw_idx_ff <= s_axi_awaddr[15:2];
        end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // read data registered at the address handshake
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_hit ? rd_data : 32'h00000000;
            rresp_ff <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule

// >>> rtl/zero_delay_mode_config.sv
// The AXI4-Lite interface to the registers was decided locally.
`include "zero_delay_cfg.svh"
module zero_delay_mode_config (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] input_select_pins,
    input wire logic [1:0] auto_pick,
    output logic zero_delay_on,
    output logic [1:0] input_choice,
    output logic [1:0] selection_source,
    output logic input3_reference_ok,
    output logic auto_switch_active,
    output logic [11:0] output_force_on_mask
);
    zero_delay_pkg::wr_req_type wr_req;
    logic wr_fire;
    logic wr_hit;
    logic [13:0] rd_idx;
    logic [31:0] rd_data;
    logic rd_hit;

    logic [1:0] map_control_ff;
    logic [2:0] normal_input_ff;
    logic selection_by_register_a_ff;
    logic selection_by_register_b_ff;
    logic [7:0] force_on_high_ff;
    logic [3:0] force_on_low_ff;
    logic zero_delay_enable_ff;
    logic [1:0] zero_delay_input_choice_ff;
    logic [2:0] mode_code_ff;
    logic code_error_ff;
    logic choice_error_ff;
    logic [1:0] pins_meta_ff;
    logic [1:0] pins_sync_ff;
    zero_delay_pkg::selection_type sel_ff;
    zero_delay_pkg::selection_type nxt_sel;

    function automatic logic idx_known(input logic [13:0] idx);
        case (idx)
            `IDX_MAP_CONTROL,
            `IDX_SELECT_STATUS,
            `IDX_NORMAL_INPUT,
            `IDX_SEL_CTRL_A,
            `IDX_FORCE_ON_HIGH,
            `IDX_FORCE_ON_LOW,
            `IDX_ZERO_DELAY_B,
            `IDX_SEL_CTRL_B,
            `IDX_MODE_CODE: idx_known = 1'b1;
            default: idx_known = 1'b0;
        endcase
    endfunction

    function automatic logic wr_to(input zero_delay_pkg::wr_req_type req,
                                   input logic [13:0] idx);
        wr_to = (req.idx == idx) && req.strb[0];
    endfunction

    axil_reg_port u_port (
        .core_clk(core_clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_req(wr_req),
        .wr_fire(wr_fire),
        .wr_hit(wr_hit),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    assign wr_hit = idx_known(wr_req.idx);
    assign rd_hit = idx_known(rd_idx);

    // pin selection crosses in from the board
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pins_meta_ff <= 2'h0;
            pins_sync_ff <= 2'h0;
        end else begin
            pins_meta_ff <= input_select_pins;
            pins_sync_ff <= pins_meta_ff;
        end
    end

    // configuration fields, each read back as written
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            map_control_ff <= `RST_MAP_CONTROL;
        end else if (wr_fire && wr_to(wr_req, `IDX_MAP_CONTROL)) begin
            map_control_ff <= wr_req.data[1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            normal_input_ff <= 3'h0;
        end else if (wr_fire && wr_to(wr_req, `IDX_NORMAL_INPUT)) begin
            normal_input_ff <= wr_req.data[2:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            selection_by_register_a_ff <= 1'b0;
            selection_by_register_b_ff <= 1'b0;
        end else if (wr_fire) begin
            if (wr_to(wr_req, `IDX_SEL_CTRL_A)) begin
                selection_by_register_a_ff <= wr_req.data[0];
            end
            if (wr_to(wr_req, `IDX_SEL_CTRL_B)) begin
                selection_by_register_b_ff <= wr_req.data[0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            force_on_high_ff <= 8'(`RST_FORCE_ON);
            force_on_low_ff <= 4'(`RST_FORCE_ON >> 8);
        end else if (wr_fire) begin
            if (wr_to(wr_req, `IDX_FORCE_ON_HIGH)) begin
                force_on_high_ff <= wr_req.data[7:0];
            end
            if (wr_to(wr_req, `IDX_FORCE_ON_LOW)) begin
                force_on_low_ff <= wr_req.data[3:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            zero_delay_enable_ff <= 1'b0;
            zero_delay_input_choice_ff <= `RST_INPUT_CHOICE;
        end else if (wr_fire && wr_to(wr_req, `IDX_ZERO_DELAY_B)) begin
            zero_delay_enable_ff <= wr_req.data[`POS_ZD_ENABLE];
            zero_delay_input_choice_ff <= wr_req.data[2:1];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_code_ff <= `RST_MODE_CODE;
        end else if (wr_fire && wr_to(wr_req, `IDX_MODE_CODE)) begin
            mode_code_ff <= wr_req.data[2:0];
        end
    end

    // sticky flags for forbidden codes; a new offence wins over clearing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            code_error_ff <= 1'b0;
            choice_error_ff <= 1'b0;
        end else if (wr_fire) begin
            if (wr_to(wr_req, `IDX_MODE_CODE) && wr_req.data[2:0] != `MODE_ZERO_DELAY &&
                wr_req.data[2:0] != `MODE_NORMAL) begin
                code_error_ff <= 1'b1;
            end else if (wr_to(wr_req, `IDX_SELECT_STATUS) &&
                         wr_req.data[`POS_CODE_ERROR]) begin
                code_error_ff <= 1'b0;
            end
            if (wr_to(wr_req, `IDX_ZERO_DELAY_B) && wr_req.data[2:1] == `CHOICE_FEEDBACK) begin
                choice_error_ff <= 1'b1;
            end else if (wr_to(wr_req, `IDX_SELECT_STATUS) &&
                         wr_req.data[`POS_CHOICE_ERROR]) begin
                choice_error_ff <= 1'b0;
            end
        end
    end

    // effective input selection
    always_comb begin
        logic variant_b;
        logic zd_on;
        logic by_register;
        logic pins_win;
        logic auto_en;
        variant_b = map_control_ff[`POS_VARIANT_B];
        zd_on = variant_b ? zero_delay_enable_ff
                          : (mode_code_ff == `MODE_ZERO_DELAY);
        by_register = variant_b ? selection_by_register_b_ff : selection_by_register_a_ff;
        auto_en = normal_input_ff[`POS_AUTO_ENABLE];
        // strict override, second map only: zero delay plus register control falls back to pins
        pins_win = !by_register ||
                   (zd_on && variant_b && by_register &&
                    map_control_ff[`POS_STRICT_OVERRIDE]);
        nxt_sel = sel_ff;
        nxt_sel.zero_delay_on = zd_on;
        nxt_sel.input3_reference_ok = !zd_on;
        nxt_sel.auto_switch_active = 1'b0;
        // a held choice must not leave input 3 as reference
        if (zd_on && sel_ff.choice == `CHOICE_FEEDBACK) begin
            nxt_sel.choice = 2'h0;
        end
        if (pins_win) begin
            // selector fields are not looked at here
            nxt_sel.source = zero_delay_pkg::SRC_PINS;
            if (!(zd_on && pins_sync_ff == `CHOICE_FEEDBACK)) begin
                nxt_sel.choice = pins_sync_ff;
            end
        end else if (zd_on) begin
            // normal selection bits unused; zero-delay field decides
            nxt_sel.source = zero_delay_pkg::SRC_ZERO_DELAY_REG;
            if (zero_delay_input_choice_ff != `CHOICE_FEEDBACK) begin
                nxt_sel.choice = zero_delay_input_choice_ff;
            end
        end else if (auto_en) begin
            // automatic switching only outside zero delay
            nxt_sel.source = zero_delay_pkg::SRC_AUTO;
            nxt_sel.auto_switch_active = 1'b1;
            nxt_sel.choice = auto_pick;
        end else begin
            nxt_sel.source = zero_delay_pkg::SRC_NORMAL_REG;
            nxt_sel.choice = normal_input_ff[1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_ff <= '{zero_delay_on: 1'b0, input3_reference_ok: 1'b1,
                        auto_switch_active: 1'b0, source: zero_delay_pkg::SRC_PINS,
                        choice: `RST_INPUT_CHOICE};
        end else begin
            sel_ff <= nxt_sel;
        end
    end

    assign zero_delay_on = sel_ff.zero_delay_on;
    assign input_choice = sel_ff.choice;
    assign selection_source = sel_ff.source;
    assign input3_reference_ok = sel_ff.input3_reference_ok;
    assign auto_switch_active = sel_ff.auto_switch_active;
    // mask bits 11:8 from the high-index register, 7:0 from the other
    assign output_force_on_mask = {force_on_low_ff, force_on_high_ff};

    // read multiplexer
    always_comb begin
        rd_data = 32'h00000000;
        case (rd_idx)
            `IDX_MAP_CONTROL: rd_data[1:0] = map_control_ff;
            `IDX_SELECT_STATUS: begin
                rd_data[1:0] = sel_ff.choice;
                rd_data[3:2] = sel_ff.source;
                rd_data[4] = sel_ff.zero_delay_on;
                rd_data[5] = sel_ff.input3_reference_ok;
                rd_data[6] = sel_ff.auto_switch_active;
                rd_data[`POS_CODE_ERROR] = code_error_ff;
                rd_data[`POS_CHOICE_ERROR] = choice_error_ff;
            end
            `IDX_NORMAL_INPUT: rd_data[2:0] = normal_input_ff;
            `IDX_SEL_CTRL_A: rd_data[0] = selection_by_register_a_ff;
            `IDX_FORCE_ON_HIGH: rd_data[7:0] = force_on_high_ff;
            `IDX_FORCE_ON_LOW: rd_data[3:0] = force_on_low_ff;
            `IDX_ZERO_DELAY_B: rd_data[2:0] = {zero_delay_input_choice_ff, zero_delay_enable_ff};
            `IDX_SEL_CTRL_B: rd_data[0] = selection_by_register_b_ff;
            `IDX_MODE_CODE: rd_data[2:0] = mode_code_ff;
            default: rd_data = 32'h00000000;
        endcase
    end
endmodule

// >>> tb/zero_delay_mode_config_checker.sv
module zero_delay_mode_config_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic zero_delay_on,
    input wire logic [1:0] input_choice,
    input wire logic [1:0] selection_source,
    input wire logic input3_reference_ok,
    input wire logic auto_switch_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence resp_late;
        !s_axi_bvalid ##[1:2] s_axi_bvalid;
    endsequence
    chk_write_answer: assert property (both_taken |=> resp_late)
        else $error("write response not on time");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read data not on time");
    chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    chk_feedback_only: assert property (input3_reference_ok == !zero_delay_on)
        else $error("input 3 offered as reference in zero delay");
    chk_zd_no_auto: assert property (zero_delay_on |-> selection_source != 2'h3)
        else $error("automatic switching under zero delay");
    chk_auto_flag: assert property (auto_switch_active == (selection_source == 2'h3))
        else $error("auto flag disagrees with source");
    chk_zd_source: assert property (zero_delay_on |-> selection_source != 2'h0)
        else $error("normal select used under zero delay");
    chk_zd_choice: assert property (zero_delay_on |-> input_choice != 2'h3)
        else $error("zero delay register picked input 3");
endmodule

// >>> tb/test_zero_delay_mode_config.sv
`include "zero_delay_cfg.svh"
module test_zero_delay_mode_config;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] map;
        logic [2:0] mode;
        logic ctla;
        logic [2:0] zd;
        logic ctlb;
        logic [2:0] nsel;
        logic [1:0] pins;
        logic [1:0] apick;
        logic e_zd;
        logic [1:0] e_src;
        logic [1:0] e_ch;
    } row_type;
    localparam row_type ROWS [9] = '{
        '{2'h0, 3'h4, 1'h1, 3'h0, 1'h0, 3'h1, 2'h0, 2'h0, 1'h0, 2'h0, 2'h1},
        '{2'h0, 3'h4, 1'h0, 3'h0, 1'h0, 3'h1, 2'h2, 2'h0, 1'h0, 2'h1, 2'h2},
        '{2'h0, 3'h3, 1'h0, 3'h0, 1'h0, 3'h1, 2'h1, 2'h0, 1'h1, 2'h1, 2'h1},
        '{2'h1, 3'h4, 1'h0, 3'h5, 1'h1, 3'h1, 2'h0, 2'h0, 1'h1, 2'h2, 2'h2},
        '{2'h1, 3'h4, 1'h0, 3'h3, 1'h0, 3'h1, 2'h2, 2'h0, 1'h1, 2'h1, 2'h2},
        '{2'h1, 3'h4, 1'h0, 3'h4, 1'h1, 3'h4, 2'h0, 2'h3, 1'h0, 2'h3, 2'h3},
        '{2'h1, 3'h4, 1'h0, 3'h1, 1'h1, 3'h4, 2'h0, 2'h3, 1'h1, 2'h2, 2'h0},
        '{2'h3, 3'h4, 1'h0, 3'h3, 1'h1, 3'h1, 2'h2, 2'h0, 1'h1, 2'h1, 2'h2},
        '{2'h1, 3'h4, 1'h0, 3'h0, 1'h1, 3'h2, 2'h0, 2'h0, 1'h0, 2'h0, 2'h2}
    };
    logic core_clk, rst;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata, last_data;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] input_select_pins, auto_pick, input_choice, selection_source;
    logic zero_delay_on, input3_reference_ok, auto_switch_active;
    logic [11:0] output_force_on_mask;
    int errors, n_tests;
    zero_delay_mode_config u_dut (
        .core_clk(core_clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .input_select_pins(input_select_pins),
        .auto_pick(auto_pick), .zero_delay_on(zero_delay_on),
        .input_choice(input_choice), .selection_source(selection_source),
        .input3_reference_ok(input3_reference_ok),
        .auto_switch_active(auto_switch_active),
        .output_force_on_mask(output_force_on_mask)
    );
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic guard(inout int n);
        n++;
        if (n > 50) begin
            errors++;
            $display("[FAIL] %0t bus wait ran out", $time);
            report_and_stop();
        end
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [13:0] idx, input logic [31:0] d);
        logic ta, tw, aw, w;
        int n;
        aw = 0;
        w = 0;
        n = 0;
        @(posedge core_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(negedge core_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge core_clk);
            aw |= ta;
            w |= tw;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
            guard(n);
        end
        do begin
            @(negedge core_clk);
            guard(n);
        end while (s_axi_bvalid !== 1'b1);
        last_resp = s_axi_bresp;
        @(posedge core_clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [13:0] idx);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge core_clk);
            guard(n);
        end while (s_axi_arready !== 1'b1);
        @(posedge core_clk);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge core_clk);
            guard(n);
        end while (s_axi_rvalid !== 1'b1);
        last_data = s_axi_rdata;
        last_resp = s_axi_rresp;
        @(posedge core_clk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic settle();
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        errors = 0;
        n_tests = 0;
        rst = 1'b1;
        s_axi_awaddr = 16'h0000;
        s_axi_araddr = 16'h0000;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b0;
        s_axi_rready = 1'b0;
        input_select_pins = 2'h0;
        auto_pick = 2'h0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        check(32'(input3_reference_ok), 32'h1, "in3 ok at reset");
        check(32'(selection_source), 32'h1, "source at reset");
        rd(`IDX_MODE_CODE);
        check(last_data, 32'h4, "mode code reset");
        $display("test reset done");
        foreach (ROWS[i]) begin
            wr(`IDX_MAP_CONTROL, 32'(ROWS[i].map));
            wr(`IDX_MODE_CODE, 32'(ROWS[i].mode));
            wr(`IDX_SEL_CTRL_A, 32'(ROWS[i].ctla));
            wr(`IDX_ZERO_DELAY_B, 32'(ROWS[i].zd));
            wr(`IDX_SEL_CTRL_B, 32'(ROWS[i].ctlb));
            wr(`IDX_NORMAL_INPUT, 32'(ROWS[i].nsel));
            input_select_pins <= ROWS[i].pins;
            auto_pick <= ROWS[i].apick;
            settle();
            check(32'(zero_delay_on), 32'(ROWS[i].e_zd), "zd on");
            check(32'(selection_source), 32'(ROWS[i].e_src), "source");
            check(32'(input_choice), 32'(ROWS[i].e_ch), "choice");
            check(32'(auto_switch_active), 32'(ROWS[i].e_src == 2'h3), "auto");
            check(32'(input3_reference_ok), 32'(!ROWS[i].e_zd), "in3 ok");
            rd(`IDX_ZERO_DELAY_B);
            check(last_data, 32'(ROWS[i].zd), "zd readback");
        end
        $display("test table done");
        wr(`IDX_FORCE_ON_HIGH, 32'h0000_00A5);
        wr(`IDX_FORCE_ON_LOW, 32'h0000_00F8);
        check(32'(last_resp), 32'(`RESP_OKAY), "mapped write");
        settle();
        check(32'(output_force_on_mask), 32'h0000_08A5, "mask out");
        rd(`IDX_FORCE_ON_LOW);
        check(last_data, 32'h0000_0008, "mask low width");
        check(32'(last_resp), 32'(`RESP_OKAY), "mapped read");
        wr(14'h0100, 32'h0000_0001);
        check(32'(last_resp), 32'(`RESP_DECERR), "unmapped write");
        rd(14'h0100);
        check(last_data, 32'h0, "unmapped data");
        check(32'(last_resp), 32'(`RESP_DECERR), "unmapped read");
        $display("test mask and unmapped done");
        wr(`IDX_ZERO_DELAY_B, 32'h0000_0005);
        wr(`IDX_ZERO_DELAY_B, 32'h0000_0007);
        settle();
        check(32'(input_choice), 32'h2, "choice held on 3");
        wr(`IDX_MAP_CONTROL, 32'h0);
        wr(`IDX_MODE_CODE, 32'(`MODE_ZERO_DELAY));
        wr(`IDX_MODE_CODE, 32'h0000_0005);
        settle();
        check(32'(zero_delay_on), 32'h0, "bad code is normal");
        rd(`IDX_SELECT_STATUS);
        check(32'(last_data[9:8]), 32'h3, "error flags");
        wr(`IDX_SELECT_STATUS, 32'h0000_0300);
        rd(`IDX_SELECT_STATUS);
        check(32'(last_data[9:8]), 32'h0, "error clear");
        $display("test forbidden values done");
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(`IDX_MODE_CODE);
        check(last_data, 32'h4, "mode code after reset");
        check(32'(zero_delay_on), 32'h0, "zd off after reset");
        $display("test second reset done");
        report_and_stop();
    end
endmodule
bind zero_delay_mode_config zero_delay_mode_config_checker u_chk (
    .core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .zero_delay_on(zero_delay_on),
    .input_choice(input_choice), .selection_source(selection_source),
    .input3_reference_ok(input3_reference_ok),
    .auto_switch_active(auto_switch_active)
);
